// ---- inc/tile_ps_pkg.sv ----
// constants and carrier types for the tile processor status register bank
// assumes a single core clock that also stands for the pll output clock
// Functional notes
// - control holds eight-bit tx data delay in pll cycles, reset zero.
// - pll-clocked counter sets tx clock at divider, clears at divider>>1.
// - control bit, zero at reset, enables the ethernet peripheral ports.
// - divider enable bit divides the pll clock for low power, reset zero.
// - mode bit one divides only while active threads pause, else always.
// - control bit picks usb transceiver style, one utmi, zero ulpi.
// - control bit enables the ulpi hardware support module.
// - read-only boot status shows processor number, boot flags, pll pins.
// - once security top bit is set, later writes to it are refused.
// - security register is loaded as a copy of the otp security word.
// - security holds debug, otp lock, redundancy, boot, jtag controls.
// - four oscillator counters, started and stopped by two enable bits.
// - four read-only registers show the 16-bit counts in their low bits.
// - ring oscillator counts survive a system reset.
// - oscillators run asynchronously to the tile clock, a random source.
// - ram size register reports bytes in bits 31:2, low bits zero.
// - debugger entry captures thread status, address space id at bit 10.
// - captured status holds fast, paused, kernel, interrupt, event flags.
// - status records kernel-entry issue mode bit 9, current bit 8.

package tile_ps_pkg;

  localparam logic [7:0] REG_TILE_CTRL = 8'h02;
  localparam logic [7:0] REG_BOOT_STATUS = 8'h03;
  localparam logic [7:0] REG_SECURITY = 8'h05;
  localparam logic [7:0] REG_OSC_CTRL = 8'h06;
  localparam logic [7:0] REG_OSC_TILE_CELL = 8'h07;
  localparam logic [7:0] REG_OSC_TILE_WIRE = 8'h08;
  localparam logic [7:0] REG_OSC_PERIPH_CELL = 8'h09;
  localparam logic [7:0] REG_OSC_PERIPH_WIRE = 8'h0a;
  localparam logic [7:0] REG_RAM_SIZE = 8'h0c;
  localparam logic [7:0] REG_DEBUG_STATUS = 8'h10;
  localparam logic [7:0] PS_RESOURCE_TYPE = 8'h0b;

  // tile feature control fields
  localparam int TX_DELAY_LSB = 18;
  localparam int TX_DIV_LSB = 9;
  localparam int RGMII_EN_BIT = 8;
  localparam int DIV_DYNAMIC_BIT = 5;
  localparam int DIV_ENABLE_BIT = 4;
  localparam int UTMI_SEL_BIT = 2;
  localparam int ULPI_EN_BIT = 1;
  localparam logic [31:0] TILE_CTRL_WMASK = 32'h03ff_ff36;
  localparam logic [31:0] TILE_CTRL_RESET = 32'h0000_0000;

  // security fields
  localparam int SEC_LOCK_BIT = 31;
  localparam logic [31:0] SEC_WMASK = 32'h8000_5fb1;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;

  // ring oscillator control
  localparam int OSC_CORE_EN_BIT = 1;
  localparam int OSC_PERIPH_EN_BIT = 0;
  localparam int OSC_COUNT_W = 16;
  localparam int OSC_STOP_MIN_CYCLES = 10;

  // ram size, plain default
  localparam logic [31:0] RAM_SIZE_BYTES = 32'h0008_0000;
  localparam logic [31:0] RAM_SIZE_MASK = 32'hffff_fffc;

  // saved thread status
  localparam logic [31:0] STATUS_WMASK = 32'h0000_06df;
  localparam logic [31:0] STATUS_CAPTURE_MASK = 32'h0000_07df;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] number;
    logic [31:0] wdata;
  } ps_request_type;

  typedef struct packed {
    logic [7:0] processor_number;
    logic boot_mode_override;
    logic core1_powered_off;
    logic skip_otp_level_poll;
    logic boot_from_ram;
    logic boot_from_jtag;
    logic [1:0] boot_pll_mode;
  } boot_status_type;

  typedef struct packed {
    logic [31:0] tile_ctrl;
    logic [31:0] security;
    logic [1:0] osc_ctrl;
    logic [3:0][OSC_COUNT_W-1:0] osc_count;
    logic [31:0] saved_thread_status;
    logic [8:0] tx_count;
    logic tx_clk;
    logic clk_div_active;
    logic [31:0] rdata;
    logic rvalid;
  } ps_state_type;

endpackage : tile_ps_pkg

// ---- hw/tile_processor_status_regs.sv ----
// tile processor status register bank with tx clock and oscillator counters
// assumes requests synchronous to clock; oscillator pulses arrive as
// single-cycle ticks already brought into the clock domain
`timescale 1ns/100ps

module tile_processor_status_regs
  import tile_ps_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire ps_request_type ps_request,
  output logic [31:0] ps_rdata,
  output logic ps_rvalid,
  input wire logic debug_mode,
  input wire logic debug_entry,
  input wire logic [31:0] thread_status_in,
  input wire boot_status_type boot_status,
  input wire logic otp_security_load,
  input wire logic [31:0] otp_security_word,
  input wire logic all_threads_paused,
  input wire logic [3:0] ring_osc_tick,
  output logic rgmii_tx_clk,
  output logic [7:0] rgmii_tx_delay,
  output logic rgmii_ports_enable,
  output logic pll_divide_active,
  output logic usb_utmi_select,
  output logic ulpi_support_enable,
  output logic [31:0] security_controls,
  output logic [1:0] ring_osc_enable
);

  // power-up value; oscillator counts never see reset
  ps_state_type state_reg = '0;
  ps_state_type state_next;

  logic [8:0] tx_div;
  logic [8:0] tx_half;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;
  logic [3:0] osc_run;

  assign tx_div = state_reg.tile_ctrl[TX_DIV_LSB +: 9];
  assign tx_half = tx_div >> 1;
  assign wr_hit = ps_request.valid && ps_request.write;
  assign rd_hit = ps_request.valid && !ps_request.write;
  // tile counters follow core enable, peripheral ones the peripheral enable
  assign osc_run = {state_reg.osc_ctrl[OSC_PERIPH_EN_BIT],
                    state_reg.osc_ctrl[OSC_PERIPH_EN_BIT],
                    state_reg.osc_ctrl[OSC_CORE_EN_BIT],
                    state_reg.osc_ctrl[OSC_CORE_EN_BIT]};

  // read mux, unmapped numbers read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (ps_request.number == REG_TILE_CTRL)
    begin
      rd_word = state_reg.tile_ctrl & TILE_CTRL_WMASK;
    end
    else if (ps_request.number == REG_BOOT_STATUS)
    begin
      rd_word = {8'h00, boot_status.processor_number, 7'h00,
                 boot_status.boot_mode_override, 2'h0,
                 boot_status.core1_powered_off,
                 boot_status.skip_otp_level_poll,
                 boot_status.boot_from_ram,
                 boot_status.boot_from_jtag,
                 boot_status.boot_pll_mode};
    end
    else if (ps_request.number == REG_SECURITY)
    begin
      rd_word = state_reg.security & SEC_WMASK;
    end
    else if (ps_request.number == REG_OSC_CTRL)
    begin
      rd_word = {30'h0000_0000, state_reg.osc_ctrl};
    end
    else if (ps_request.number == REG_OSC_TILE_CELL)
    begin
      rd_word = {16'h0000, state_reg.osc_count[0]};
    end
    else if (ps_request.number == REG_OSC_TILE_WIRE)
    begin
      rd_word = {16'h0000, state_reg.osc_count[1]};
    end
    else if (ps_request.number == REG_OSC_PERIPH_CELL)
    begin
      rd_word = {16'h0000, state_reg.osc_count[2]};
    end
    else if (ps_request.number == REG_OSC_PERIPH_WIRE)
    begin
      rd_word = {16'h0000, state_reg.osc_count[3]};
    end
    else if (ps_request.number == REG_RAM_SIZE)
    begin
      rd_word = RAM_SIZE_BYTES & RAM_SIZE_MASK;
    end
    else if (ps_request.number == REG_DEBUG_STATUS)
    begin
      rd_word = state_reg.saved_thread_status & STATUS_CAPTURE_MASK;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.rvalid = rd_hit;
    state_next.rdata = rd_hit ? rd_word : 32'h0000_0000;

    // masked writes, reserved bits stay zero
    if (wr_hit && ps_request.number == REG_TILE_CTRL)
    begin
      state_next.tile_ctrl = ps_request.wdata & TILE_CTRL_WMASK;
    end
    if (wr_hit && ps_request.number == REG_OSC_CTRL)
    begin
      state_next.osc_ctrl = ps_request.wdata[1:0];
    end
    // lock bit refuses writes; otp copy still loads
    if (wr_hit && ps_request.number == REG_SECURITY &&
        !state_reg.security[SEC_LOCK_BIT])
    begin
      state_next.security = ps_request.wdata & SEC_WMASK;
    end
    if (otp_security_load)
    begin
      state_next.security = otp_security_word & SEC_WMASK;
    end
    // debugger-writable only in debug mode; capture wins over a write
    if (wr_hit && ps_request.number == REG_DEBUG_STATUS && debug_mode)
    begin
      state_next.saved_thread_status =
        (ps_request.wdata & STATUS_WMASK) |
        (state_reg.saved_thread_status & ~STATUS_WMASK);
    end
    if (debug_entry)
    begin
      state_next.saved_thread_status =
        thread_status_in & STATUS_CAPTURE_MASK;
    end

    // ring oscillator counts, free running while enabled
    for (int i = 0; i < 4; i++)
    begin
      if (osc_run[i] && ring_osc_tick[i])
      begin
        state_next.osc_count[i] =
          OSC_COUNT_W'(state_reg.osc_count[i] + 1'b1);
      end
    end

    // tx clock divider counter
    if (state_reg.tx_count >= tx_div)
    begin
      state_next.tx_count = 9'h000;
    end
    else
    begin
      state_next.tx_count = 9'(state_reg.tx_count + 1'b1);
    end
    if (state_reg.tx_count == tx_div)
    begin
      state_next.tx_clk = 1'b1;
    end
    else if (state_reg.tx_count == tx_half)
    begin
      state_next.tx_clk = 1'b0;
    end

    state_next.clk_div_active =
      state_reg.tile_ctrl[DIV_ENABLE_BIT] &&
      (!state_reg.tile_ctrl[DIV_DYNAMIC_BIT] ||
       all_threads_paused);

    if (reset)
    begin
      state_next.tile_ctrl = TILE_CTRL_RESET;
      state_next.security = SEC_RESET;
      state_next.osc_ctrl = 2'h0;
      state_next.saved_thread_status = STATUS_RESET;
      state_next.tx_count = 9'h000;
      state_next.tx_clk = 1'b0;
      state_next.clk_div_active = 1'b0;
      state_next.rdata = 32'h0000_0000;
      state_next.rvalid = 1'b0;
      state_next.osc_count = state_reg.osc_count;
    end
  end

  always_ff @(posedge clock)
  begin
    state_reg <= state_next;
  end

  assign ps_rdata = state_reg.rdata;
  assign ps_rvalid = state_reg.rvalid;
  assign rgmii_tx_clk = state_reg.tx_clk;
  assign rgmii_tx_delay = state_reg.tile_ctrl[TX_DELAY_LSB +: 8];
  assign rgmii_ports_enable = state_reg.tile_ctrl[RGMII_EN_BIT];
  assign pll_divide_active = state_reg.clk_div_active;
  assign usb_utmi_select = state_reg.tile_ctrl[UTMI_SEL_BIT];
  assign ulpi_support_enable = state_reg.tile_ctrl[ULPI_EN_BIT];
  assign security_controls = state_reg.security;
  assign ring_osc_enable = state_reg.osc_ctrl;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence s_sec_write;
    wr_hit && ps_request.number == REG_SECURITY && !otp_security_load;
  endsequence

  sequence s_status_write_outside_debug;
    wr_hit && ps_request.number == REG_DEBUG_STATUS && !debug_mode &&
    !debug_entry;
  endsequence

  sequence s_read_ram_size;
    rd_hit && ps_request.number == REG_RAM_SIZE;
  endsequence

  sequence s_ctrl_write;
    wr_hit && ps_request.number == REG_TILE_CTRL;
  endsequence

  sequence s_status_write_in_debug;
    wr_hit && ps_request.number == REG_DEBUG_STATUS && debug_mode &&
    !debug_entry;
  endsequence

  property p_tx_rise;
    state_reg.tx_count == tx_div |=> rgmii_tx_clk;
  endproperty
  a_tx_rise: assert property (p_tx_rise)
    else $error("tx clock did not rise at divider value");

  property p_tx_fall;
    state_reg.tx_count == tx_half && state_reg.tx_count != tx_div
      |=> !rgmii_tx_clk;
  endproperty
  a_tx_fall: assert property (p_tx_fall)
    else $error("tx clock did not fall at half divider value");

  property p_sec_locked;
    state_reg.security[SEC_LOCK_BIT] ##0 s_sec_write
      |=> $stable(state_reg.security);
  endproperty
  a_sec_locked: assert property (p_sec_locked)
    else $error("security register changed while locked");

  property p_otp_copy;
    otp_security_load |=>
      security_controls == ($past(otp_security_word) & SEC_WMASK);
  endproperty
  a_otp_copy: assert property (p_otp_copy)
    else $error("security register is not the otp copy");

  property p_osc_stopped;
    !osc_run[0] ##1 !osc_run[0] |-> $stable(state_reg.osc_count[0]);
  endproperty
  a_osc_stopped: assert property (p_osc_stopped)
    else $error("stopped oscillator count moved");

  property p_osc_counts;
    osc_run[2] && ring_osc_tick[2] |=>
      state_reg.osc_count[2] ==
        OSC_COUNT_W'($past(state_reg.osc_count[2]) + 1'b1);
  endproperty
  a_osc_counts: assert property (p_osc_counts)
    else $error("running oscillator count did not advance");

  property p_ram_size_read;
    s_read_ram_size |=> ps_rvalid && ps_rdata == RAM_SIZE_BYTES &&
      ps_rdata[1:0] == 2'h0;
  endproperty
  a_ram_size_read: assert property (p_ram_size_read)
    else $error("ram size read returned wrong word");

  property p_status_capture;
    debug_entry |=> state_reg.saved_thread_status ==
      ($past(thread_status_in) & STATUS_CAPTURE_MASK);
  endproperty
  a_status_capture: assert property (p_status_capture)
    else $error("thread status not captured on debug entry");

  property p_status_guarded;
    s_status_write_outside_debug |=>
      $stable(state_reg.saved_thread_status);
  endproperty
  a_status_guarded: assert property (p_status_guarded)
    else $error("status word written outside debug mode");

  property p_status_bit8;
    s_status_write_in_debug |=> $stable(state_reg.saved_thread_status[8]);
  endproperty
  a_status_bit8: assert property (p_status_bit8)
    else $error("read-only issue mode bit was written");

  property p_div_static;
    state_reg.tile_ctrl[DIV_ENABLE_BIT] &&
    !state_reg.tile_ctrl[DIV_DYNAMIC_BIT] |=> pll_divide_active;
  endproperty
  a_div_static: assert property (p_div_static)
    else $error("static divide not active");

  property p_div_off;
    !state_reg.tile_ctrl[DIV_ENABLE_BIT] |=> !pll_divide_active;
  endproperty
  a_div_off: assert property (p_div_off)
    else $error("divide active while disabled");

  property p_reserved_zero;
    rd_hit && ps_request.number == REG_OSC_CTRL |=> ps_rvalid &&
      ps_rdata == {30'h0000_0000, $past(ring_osc_enable)};
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("oscillator control read wrong or reserved bit set");

  property p_ctrl_reserved;
    rd_hit && ps_request.number == REG_TILE_CTRL |=>
      (ps_rdata & ~TILE_CTRL_WMASK) == 32'h0000_0000;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("tile control reserved bits read as one");

  property p_read_answer;
    rd_hit |=> ps_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered in the next cycle");

  property p_idle_answer;
    !rd_hit |=> !ps_rvalid && ps_rdata == 32'h0000_0000;
  endproperty
  a_idle_answer: assert property (p_idle_answer)
    else $error("read answer without a read");

  property p_tx_delay_out;
    s_ctrl_write |=>
      rgmii_tx_delay == $past(ps_request.wdata[TX_DELAY_LSB +: 8]);
  endproperty
  a_tx_delay_out: assert property (p_tx_delay_out)
    else $error("tx delay output does not follow the write");

  property p_ports_enable;
    s_ctrl_write |=>
      rgmii_ports_enable == $past(ps_request.wdata[RGMII_EN_BIT]);
  endproperty
  a_ports_enable: assert property (p_ports_enable)
    else $error("port enable does not follow the write");

  property p_usb_select;
    s_ctrl_write |=>
      usb_utmi_select == $past(ps_request.wdata[UTMI_SEL_BIT]);
  endproperty
  a_usb_select: assert property (p_usb_select)
    else $error("transceiver select does not follow the write");

  property p_ulpi_enable;
    s_ctrl_write |=>
      ulpi_support_enable == $past(ps_request.wdata[ULPI_EN_BIT]);
  endproperty
  a_ulpi_enable: assert property (p_ulpi_enable)
    else $error("ulpi support enable does not follow the write");

  property p_boot_read;
    rd_hit && ps_request.number == REG_BOOT_STATUS |=>
      ps_rdata[23:16] == $past(boot_status.processor_number) &&
      ps_rdata[8] == $past(boot_status.boot_mode_override) &&
      ps_rdata[1:0] == $past(boot_status.boot_pll_mode);
  endproperty
  a_boot_read: assert property (p_boot_read)
    else $error("boot status read does not show the pins");

  property p_osc_kept;
    disable iff (1'b0)
    reset |=> $stable(state_reg.osc_count);
  endproperty
  a_osc_kept: assert property (p_osc_kept)
    else $error("oscillator counts changed in reset");

  property p_div_dynamic;
    state_reg.tile_ctrl[DIV_ENABLE_BIT] &&
    state_reg.tile_ctrl[DIV_DYNAMIC_BIT] && !all_threads_paused
      |=> !pll_divide_active;
  endproperty
  a_div_dynamic: assert property (p_div_dynamic)
    else $error("dynamic divide active while threads run");

endmodule : tile_processor_status_regs

// ---- bench/tile_processor_status_regs_tb.sv ----
// self-checking bench for the tile processor status register bank
// assumes one 100 MHz clock; all inputs driven at the falling edge
`timescale 1ns/100ps

module tile_processor_status_regs_tb;
  import tile_ps_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  ps_request_type req = '0;
  logic [31:0] ps_rdata, tsi = '0, otpw = '0, sec_o, d;
  logic ps_rvalid, dbg_mode = 1'b0, dbg_entry = 1'b0, otp_ld = 1'b0;
  logic paused = 1'b0, tx_clk, ports_en, div_act, utmi, ulpi;
  logic [3:0] tick = '0;
  logic [7:0] tx_dly;
  logic [1:0] osc_en;
  boot_status_type boot = '0;
  logic [15:0] base [4];
  int err_total = 0;
  int samples_checked = 0;

  tile_processor_status_regs i_tile_processor_status_regs (
    .clock(clock), .reset(reset), .ps_request(req), .ps_rdata(ps_rdata),
    .ps_rvalid(ps_rvalid), .debug_mode(dbg_mode), .debug_entry(dbg_entry),
    .thread_status_in(tsi), .boot_status(boot), .otp_security_load(otp_ld),
    .otp_security_word(otpw), .all_threads_paused(paused),
    .ring_osc_tick(tick), .rgmii_tx_clk(tx_clk), .rgmii_tx_delay(tx_dly),
    .rgmii_ports_enable(ports_en), .pll_divide_active(div_act),
    .usb_utmi_select(utmi), .ulpi_support_enable(ulpi),
    .security_controls(sec_o), .ring_osc_enable(osc_en));

  initial
  begin
    forever #5 clock = ~clock;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] n, input logic [31:0] v);
    logic [31:0] rid;
    rid = {16'h0000, n, PS_RESOURCE_TYPE};
    @(negedge clock);
    req = '{1'b1, 1'b1, rid[15:8], v};
    @(negedge clock);
    req = '0;
  endtask : wr

  // read answer sampled at the falling edge half a cycle after the taking edge
  task automatic rd(input logic [7:0] n, output logic [31:0] v);
    int i;
    logic [31:0] rid;
    rid = {16'h0000, n, PS_RESOURCE_TYPE};
    @(negedge clock);
    req = '{1'b1, 1'b0, rid[15:8], 32'h0};
    @(negedge clock);
    req = '0;
    for (i = 0; i < 4 && ps_rvalid !== 1'b1; i++)
      @(negedge clock);
    if (ps_rvalid !== 1'b1)
    begin
      err_total++;
      $display("[ERR] %0t read of %h not answered", $time, n);
      give_verdict();
    end
    v = ps_rdata;
  endtask : rd

  task automatic t_reset_values();
    rd(REG_TILE_CTRL, d);
    chk(d, 32'h0, "ctrl reset");
    rd(REG_SECURITY, d);
    chk(d, 32'h0, "sec reset");
    rd(REG_OSC_CTRL, d);
    chk(d, 32'h0, "osc reset");
    chk({tx_dly, ports_en, div_act}, 32'h0, "outputs reset");
    rd(REG_RAM_SIZE, d);
    chk(d, RAM_SIZE_BYTES & RAM_SIZE_MASK, "ram");
    wr(8'h04, 32'hffff_ffff);
    rd(8'h04, d);
    chk(d, 32'h0, "unmapped");
  endtask : t_reset_values

  task automatic t_tile_ctrl();
    int i, hi;
    wr(REG_TILE_CTRL, 32'hffff_ffff);
    rd(REG_TILE_CTRL, d);
    chk(d, 32'h03ff_ff36, "ctrl mask");
    chk(tx_dly, 8'hff, "tx delay");
    chk({ports_en, utmi, ulpi}, 3'h7, "ctrl bits");
    wr(REG_TILE_CTRL, 32'h0000_0002);
    chk({utmi, ulpi}, 2'h1, "ulpi mode");
    wr(REG_TILE_CTRL, 32'h0000_0004);
    chk({utmi, ulpi}, 2'h2, "utmi mode");
    // divide by four: field holds three
    wr(REG_TILE_CTRL, 32'h0000_0003 << 9);
    repeat (8) @(negedge clock);
    hi = 0;
    for (i = 0; i < 40; i++)
    begin
      @(negedge clock);
      hi += (tx_clk === 1'b1);
    end
    chk(hi, 20, "tx clk duty");
    wr(REG_TILE_CTRL, 32'h0);
    repeat (4) @(negedge clock);
    chk(tx_clk, 1'b1, "div zero high");
  endtask : t_tile_ctrl

  task automatic t_divider();
    wr(REG_TILE_CTRL, 32'h10);
    @(negedge clock);
    chk(div_act, 1'b1, "static divide");
    wr(REG_TILE_CTRL, 32'h30);
    @(negedge clock);
    chk(div_act, 1'b0, "dynamic running");
    paused = 1'b1;
    repeat (2) @(negedge clock);
    chk(div_act, 1'b1, "dynamic paused");
    wr(REG_TILE_CTRL, 32'h20);
    @(negedge clock);
    chk(div_act, 1'b0, "divider off");
    paused = 1'b0;
  endtask : t_divider

  task automatic t_boot();
    boot = '{8'ha5, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'h2};
    rd(REG_BOOT_STATUS, d);
    chk(d, 32'h00a5_0116, "boot 1");
    boot = '{8'h5a, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h1};
    wr(REG_BOOT_STATUS, 32'h0);
    rd(REG_BOOT_STATUS, d);
    chk(d, 32'h005a_0029, "boot 2");
  endtask : t_boot

  task automatic t_security();
    otpw = 32'h7fff_ffff;
    otp_ld = 1'b1;
    @(negedge clock);
    otp_ld = 1'b0;
    rd(REG_SECURITY, d);
    chk(d, 32'h0000_5fb1, "otp copy");
    chk(sec_o, 32'h0000_5fb1, "sec controls");
    wr(REG_SECURITY, 32'h0000_1100);
    rd(REG_SECURITY, d);
    chk(d, 32'h0000_1100, "sec write");
    wr(REG_SECURITY, 32'h8000_0001);
    wr(REG_SECURITY, 32'h0000_4000);
    rd(REG_SECURITY, d);
    chk(d, 32'h8000_0001, "sec locked");
  endtask : t_security

  task automatic t_debug();
    tsi = 32'hffff_ffff;
    dbg_entry = 1'b1;
    @(negedge clock);
    dbg_entry = 1'b0;
    rd(REG_DEBUG_STATUS, d);
    chk(d, 32'h0000_07df, "capture");
    wr(REG_DEBUG_STATUS, 32'h0);
    rd(REG_DEBUG_STATUS, d);
    chk(d, 32'h0000_07df, "no debug");
    dbg_mode = 1'b1;
    wr(REG_DEBUG_STATUS, 32'h0);
    rd(REG_DEBUG_STATUS, d);
    chk(d, 32'h0000_0100, "bit8 ro");
    dbg_mode = 1'b0;
  endtask : t_debug

  task automatic t_osc();
    int k;
    wr(REG_OSC_CTRL, 32'h0);
    repeat (10) @(negedge clock);
    for (k = 0; k < 4; k++)
    begin
      rd(REG_OSC_TILE_CELL + k[7:0], d);
      base[k] = d[15:0];
      chk(d[31:16], 16'h0, "osc upper");
    end
    wr(REG_OSC_CTRL, 32'hffff_fffe);
    chk(osc_en, 2'h2, "core only");
    repeat (3)
    begin
      @(negedge clock);
      tick = 4'hf;
      @(negedge clock);
      tick = 4'h0;
    end
    wr(REG_OSC_CTRL, 32'h1);
    chk(osc_en, 2'h1, "periph only");
    @(negedge clock);
    tick = 4'hf;
    @(negedge clock);
    tick = 4'h0;
    wr(REG_OSC_CTRL, 32'h0);
    // ticks while stopped must not count
    @(negedge clock);
    tick = 4'hf;
    @(negedge clock);
    tick = 4'h0;
    repeat (10) @(negedge clock);
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    chk(osc_en, 2'h0, "enable reset");
    for (k = 0; k < 4; k++)
    begin
      rd(REG_OSC_TILE_CELL + k[7:0], d);
      chk(d, {16'h0, base[k] + ((k < 2) ? 16'h3 : 16'h1)}, "count");
    end
  endtask : t_osc

  initial
  begin
    repeat (12) @(negedge clock);
    reset = 1'b0;
    t_reset_values();
    t_tile_ctrl();
    t_divider();
    t_boot();
    t_security();
    t_debug();
    t_osc();
    give_verdict();
  end
endmodule : tile_processor_status_regs_tb
